// [design/cbs_exec.sv]
// Branch, skip, bit-mask, compare and I/O bit execution unit with an APB register port
//
// Function
// RQ1 - Set-bits ORs immediate mask into destination in one cycle; Z, N, V updated.
// RQ2 - Clear-bits ANDs destination with 0xFF minus mask in one cycle; Z, N, V.
// RQ3 - Test ANDs register with itself, value kept, Z, N, V set, one cycle.
// RQ4 - Indirect jump loads PC from Z pointer, no flags, two cycles.
// RQ5 - Indirect call pushes return address, loads PC from Z, three cycles.
// RQ6 - Compare-and-skip advances PC by 2 or 3 when equal, no flags.
// RQ7 - Compare immediate sets Z, N, V, C, H from register minus constant, unstored.
// RQ8 - Skip when selected general register bit is zero, no flags changed.
// RQ9 - Skip when selected general register bit is one, no flags changed.
// RQ10 - I/O bit skips test one I/O register bit, clear or set form.
// RQ11 - Generic flag branches add k plus 1 when selected bit set or clear.
// RQ12 - Signed greater-or-equal branch taken only when N xor V is zero.
// RQ13 - Signed less-than branch taken only when N xor V is one.
// RQ14 - Same-or-higher branch on carry zero, lower branch on carry one.
// RQ15 - Carry-clear branch on carry zero, carry-set branch on carry one.
// RQ16 - Half-carry branches follow H set or cleared, one or two cycles.
// RQ17 - Transfer-bit branches follow T set or cleared, one or two cycles.
// RQ18 - Overflow branches follow V set or cleared, changing no flags.
// RQ19 - Interrupt-state branches follow global interrupt enable set or cleared.
// RQ20 - I/O bit-set forces one addressed bit to one in two cycles.
// RQ21 - I/O bit-clear forces one addressed bit to zero in two cycles.
// RQ22 - Untaken branch one cycle, taken two; two-word skip takes three.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "cbs_params.svh"

module cbs_exec #(
  parameter int IO_REGS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic exec_busy
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The I/O window holds 32 word slots and bit operations address 5 bits
  if (IO_REGS < 1 || IO_REGS > 32) begin : g_io_check
    $error("IO_REGS must lie between 1 and 32");
  end

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Picks one bit of a byte, shared by flag, register and I/O tests
  function automatic logic cbs_bit(input logic [7:0] v, input logic [2:0] s);
    cbs_bit = v[s];
  endfunction : cbs_bit

  // Tells whether an address maps to a register or an I/O slot
  function automatic logic cbs_mapped(input logic [7:0] a);
    cbs_mapped = (a == `CBS_OFF_OP) || (a == `CBS_OFF_OPND) || (a == `CBS_OFF_PC) ||
                 (a == `CBS_OFF_ZPTR) || (a == `CBS_OFF_SP) || (a == `CBS_OFF_FLAGS) ||
                 (a == `CBS_OFF_RESULT) || (a == `CBS_OFF_STAT) || (a == `CBS_OFF_RET) ||
                 ((a >= `CBS_OFF_IO_BASE) && (a[1:0] == 2'h0) &&
                  (32'(a[6:2]) < IO_REGS));
  endfunction : cbs_mapped

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cbs_pkg::cbs_state_e state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [2:0] cyc_last_reg, cyc_last_next;
  logic [31:0] opnd_reg, opnd_next;
  logic [15:0] pc_reg, pc_next;
  logic [15:0] z_reg, z_next;
  logic [15:0] sp_reg, sp_next;
  logic [15:0] ret_reg, ret_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] result_reg, result_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [7:0] io_reg [IO_REGS];
  logic [7:0] io_next [IO_REGS];
  // Values computed at launch and applied on the last execution cycle
  logic [15:0] pend_pc_reg, pend_pc_next;
  logic [7:0] pend_flags_reg, pend_flags_next;
  logic [7:0] pend_res_reg, pend_res_next;
  logic pend_push_reg, pend_push_next;
  logic pend_io_we_reg, pend_io_we_next;
  logic [4:0] pend_io_addr_reg, pend_io_addr_next;
  logic [7:0] pend_io_val_reg, pend_io_val_next;

  // ----------------------------------------------------------------------
  // Bus decode and operand views
  // ----------------------------------------------------------------------
  logic acc, wr_acc, bad_acc, launch, commit;
  cbs_pkg::cbs_op_e op_code;
  logic [2:0] op_sel;
  logic [4:0] op_io;
  logic op_two;
  logic [7:0] d_val, r_val, kimm, io_val, io_mask;
  logic [15:0] kofs;

  // Access phase and refusal of bad addresses, busy writes, unknown codes
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  assign bad_acc = !cbs_mapped(paddr) ||
                   (pwrite && (state_reg != cbs_pkg::st_idle) && (paddr != `CBS_OFF_OPND)) ||
                   (pwrite && (paddr == `CBS_OFF_OP) && (pwdata[`CBS_OPF_CODE] >= `CBS_OP_COUNT));
  assign launch = wr_acc && !bad_acc && (paddr == `CBS_OFF_OP);
  assign commit = (state_reg == cbs_pkg::st_busy) && (cnt_reg == `CBS_CYC_ONE);
  assign pready = 1'b1;
  assign pslverr = acc && bad_acc;
  assign prdata = prdata_reg;
  assign exec_busy = (state_reg == cbs_pkg::st_busy);

  // Operation fields of the launching write and operand register fields
  assign op_code = cbs_pkg::cbs_op_e'(pwdata[`CBS_OPF_CODE]);
  assign op_sel = pwdata[`CBS_OPF_SEL];
  assign op_io = pwdata[`CBS_OPF_IO];
  assign op_two = pwdata[`CBS_OPF_TWO];
  assign d_val = opnd_reg[`CBS_ODF_D];
  assign r_val = opnd_reg[`CBS_ODF_R];
  assign kimm = opnd_reg[`CBS_ODF_KIMM];
  assign kofs = {{8{opnd_reg[31]}}, opnd_reg[`CBS_ODF_KOFS]};
  assign io_val = (32'(op_io) < IO_REGS) ? io_reg[op_io] : 8'h00;
  assign io_mask = 8'(8'h01 << op_sel);

  // ----------------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------------
  logic [7:0] x_res, x_flags, x_diff;
  logic [15:0] x_pc;
  logic [2:0] x_cyc;
  logic x_skip, x_take, x_logic, x_push, x_io_we;
  logic [7:0] x_io_val;

  // Works out result, flags, next PC and cycle count of the launching op
  always_comb begin
    x_res = result_reg; // Only logic ops change the result
    x_flags = flags_reg;
    x_diff = 8'(d_val - kimm);
    x_pc = pc_reg + `CBS_PC_STEP;
    x_cyc = `CBS_CYC_ONE;
    x_skip = 1'b0;
    x_take = 1'b0;
    x_logic = 1'b0;
    x_push = 1'b0;
    x_io_we = 1'b0;
    x_io_val = io_val;
    case (op_code)
      cbs_pkg::set_bits_op: begin
        x_res = d_val | kimm; // see RQ1
        x_logic = 1'b1;
      end
      cbs_pkg::clear_bits_op: begin
        x_res = d_val & (`CBS_BYTE_ONES - kimm); // see RQ2
        x_logic = 1'b1;
      end
      cbs_pkg::test_zero_minus_op: begin
        x_res = d_val & d_val; // see RQ3
        x_logic = 1'b1;
      end
      cbs_pkg::indirect_jump_op: begin
        x_pc = z_reg; // see RQ4
        x_cyc = `CBS_CYC_TWO;
      end
      cbs_pkg::indirect_call_op: begin
        x_pc = z_reg; // see RQ5
        x_push = 1'b1;
        x_cyc = `CBS_CYC_THREE;
      end
      cbs_pkg::compare_skip_equal_op: x_skip = (d_val == r_val); // see RQ6
      cbs_pkg::compare_immediate_op: begin
        // Difference kept out of the result; borrow flags from bits 7 and 3
        x_flags[`CBS_FLAG_Z] = (x_diff == 8'h00); // see RQ7
        x_flags[`CBS_FLAG_N] = x_diff[7];
        x_flags[`CBS_FLAG_V] = (d_val[7] & ~kimm[7] & ~x_diff[7]) | (~d_val[7] & kimm[7] & x_diff[7]);
        x_flags[`CBS_FLAG_C] = (~d_val[7] & kimm[7]) | (kimm[7] & x_diff[7]) | (x_diff[7] & ~d_val[7]);
        x_flags[`CBS_FLAG_H] = (~d_val[3] & kimm[3]) | (kimm[3] & x_diff[3]) | (x_diff[3] & ~d_val[3]);
      end
      cbs_pkg::skip_reg_bit_clear_op: x_skip = !cbs_bit(d_val, op_sel); // see RQ8
      cbs_pkg::skip_reg_bit_set_op: x_skip = cbs_bit(d_val, op_sel); // see RQ9
      cbs_pkg::skip_io_bit_clear_op: x_skip = !cbs_bit(io_val, op_sel); // see RQ10
      cbs_pkg::skip_io_bit_set_op: x_skip = cbs_bit(io_val, op_sel); // see RQ10
      cbs_pkg::branch_flag_set_op: x_take = cbs_bit(flags_reg, op_sel); // see RQ11
      cbs_pkg::branch_flag_clear_op: x_take = !cbs_bit(flags_reg, op_sel); // see RQ11
      cbs_pkg::branch_signed_ge_op: x_take = !(flags_reg[`CBS_FLAG_N] ^ flags_reg[`CBS_FLAG_V]); // see RQ12
      cbs_pkg::branch_signed_lt_op: x_take = flags_reg[`CBS_FLAG_N] ^ flags_reg[`CBS_FLAG_V]; // see RQ13
      cbs_pkg::branch_unsigned_ge_op: x_take = !flags_reg[`CBS_FLAG_C]; // see RQ14
      cbs_pkg::branch_unsigned_lt_op: x_take = flags_reg[`CBS_FLAG_C]; // see RQ14
      cbs_pkg::branch_carry_clear_op: x_take = !flags_reg[`CBS_FLAG_C]; // see RQ15
      cbs_pkg::branch_carry_set_op: x_take = flags_reg[`CBS_FLAG_C]; // see RQ15
      cbs_pkg::branch_halfcarry_set_op: x_take = flags_reg[`CBS_FLAG_H]; // see RQ16
      cbs_pkg::branch_halfcarry_clear_op: x_take = !flags_reg[`CBS_FLAG_H]; // see RQ16
      cbs_pkg::branch_transfer_set_op: x_take = flags_reg[`CBS_FLAG_T]; // see RQ17
      cbs_pkg::branch_transfer_clear_op: x_take = !flags_reg[`CBS_FLAG_T]; // see RQ17
      cbs_pkg::branch_overflow_set_op: x_take = flags_reg[`CBS_FLAG_V]; // see RQ18
      cbs_pkg::branch_overflow_clear_op: x_take = !flags_reg[`CBS_FLAG_V]; // see RQ18
      cbs_pkg::branch_irq_enabled_op: x_take = flags_reg[`CBS_FLAG_I]; // see RQ19
      cbs_pkg::branch_irq_disabled_op: x_take = !flags_reg[`CBS_FLAG_I]; // see RQ19
      cbs_pkg::io_bit_set_op: begin
        x_io_we = 1'b1;
        x_io_val = io_val | io_mask; // see RQ20
        x_cyc = `CBS_CYC_TWO;
      end
      cbs_pkg::io_bit_clear_op: begin
        x_io_we = 1'b1;
        x_io_val = io_val & ~io_mask; // see RQ21
        x_cyc = `CBS_CYC_TWO;
      end
      default: x_cyc = `CBS_CYC_ONE;
    endcase
    // Logical ops: Z and N from the result, V cleared
    if (x_logic) begin
      x_flags[`CBS_FLAG_Z] = (x_res == 8'h00);
      x_flags[`CBS_FLAG_N] = x_res[7];
      x_flags[`CBS_FLAG_V] = 1'b0;
    end
    // Skip past a one- or two-word instruction
    if (x_skip) begin
      x_pc = pc_reg + (op_two ? `CBS_SKIP_TWO : `CBS_SKIP_ONE); // see RQ22
      x_cyc = op_two ? `CBS_CYC_THREE : `CBS_CYC_TWO; // see RQ22
    end
    // Taken branch lands at PC plus k plus one
    if (x_take) begin
      x_pc = pc_reg + kofs + `CBS_PC_STEP; // see RQ11
      x_cyc = `CBS_CYC_TWO; // see RQ22
    end
  end

  // ----------------------------------------------------------------------
  // Registers, sequencer and read data
  // ----------------------------------------------------------------------
  // Next state of every register: bus writes, launch capture, commit
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cyc_last_next = cyc_last_reg;
    opnd_next = opnd_reg;
    pc_next = pc_reg;
    z_next = z_reg;
    sp_next = sp_reg;
    ret_next = ret_reg;
    flags_next = flags_reg;
    result_next = result_reg;
    io_next = io_reg;
    pend_pc_next = pend_pc_reg;
    pend_flags_next = pend_flags_reg;
    pend_res_next = pend_res_reg;
    pend_push_next = pend_push_reg;
    pend_io_we_next = pend_io_we_reg;
    pend_io_addr_next = pend_io_addr_reg;
    pend_io_val_next = pend_io_val_reg;
    prdata_next = 32'h0000_0000;
    // Software writes, only while idle except the operand word
    if (wr_acc && !bad_acc) begin
      case (paddr)
        `CBS_OFF_OPND: opnd_next = pwdata;
        `CBS_OFF_PC: pc_next = pwdata[15:0];
        `CBS_OFF_ZPTR: z_next = pwdata[15:0];
        `CBS_OFF_SP: sp_next = pwdata[15:0];
        `CBS_OFF_FLAGS: flags_next = pwdata[7:0];
        default: begin
          if (paddr >= `CBS_OFF_IO_BASE) begin
            io_next[paddr[6:2]] = pwdata[7:0];
          end
        end
      endcase
    end
    case (state_reg)
      cbs_pkg::st_idle: begin
        if (launch) begin
          state_next = cbs_pkg::st_busy;
          cnt_next = x_cyc;
          pend_pc_next = x_pc;
          pend_flags_next = x_flags;
          pend_res_next = x_res;
          pend_push_next = x_push;
          pend_io_we_next = x_io_we;
          pend_io_addr_next = op_io;
          pend_io_val_next = x_io_val;
        end
      end
      cbs_pkg::st_busy: begin
        cnt_next = cnt_reg - `CBS_CYC_ONE;
        if (commit) begin
          state_next = cbs_pkg::st_idle;
          cyc_last_next = cyc_last_reg;
          pc_next = pend_pc_reg;
          flags_next = pend_flags_reg;
          result_next = pend_res_reg;
          if (pend_push_reg) begin
            ret_next = pc_reg + `CBS_PC_STEP; // see RQ5
            sp_next = sp_reg - `CBS_SP_STEP; // see RQ5
          end
          if (pend_io_we_reg && (32'(pend_io_addr_reg) < IO_REGS)) begin
            io_next[pend_io_addr_reg] = pend_io_val_reg; // see RQ20
          end
        end
      end
      default: state_next = cbs_pkg::st_idle;
    endcase
    if (launch) begin
      cyc_last_next = x_cyc;
    end
    // Read data captured in the setup cycle, held through the access
    if (psel && !penable && !pwrite && cbs_mapped(paddr)) begin
      case (paddr)
        `CBS_OFF_OPND: prdata_next = opnd_reg;
        `CBS_OFF_PC: prdata_next = {16'h0000, pc_reg};
        `CBS_OFF_ZPTR: prdata_next = {16'h0000, z_reg};
        `CBS_OFF_SP: prdata_next = {16'h0000, sp_reg};
        `CBS_OFF_FLAGS: prdata_next = {24'h000000, flags_reg};
        `CBS_OFF_RESULT: prdata_next = {24'h000000, result_reg};
        `CBS_OFF_STAT: prdata_next = {23'h000000, exec_busy, 5'h00, cyc_last_reg};
        `CBS_OFF_RET: prdata_next = {16'h0000, ret_reg};
        `CBS_OFF_OP: prdata_next = 32'h0000_0000;
        default: prdata_next = {24'h000000, io_reg[paddr[6:2]]};
      endcase
    end else if (psel && penable) begin
      prdata_next = prdata_reg;
    end
  end

  // Registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= cbs_pkg::st_idle;
      cnt_reg <= 3'h0;
      cyc_last_reg <= 3'h0;
      opnd_reg <= 32'h0000_0000;
      pc_reg <= `CBS_PC_RST;
      z_reg <= `CBS_Z_RST;
      sp_reg <= `CBS_SP_RST;
      ret_reg <= 16'h0000;
      flags_reg <= `CBS_FLAGS_RST;
      result_reg <= 8'h00;
      prdata_reg <= 32'h0000_0000;
      io_reg <= '{default: 8'h00};
      pend_pc_reg <= 16'h0000;
      pend_flags_reg <= 8'h00;
      pend_res_reg <= 8'h00;
      pend_push_reg <= 1'b0;
      pend_io_we_reg <= 1'b0;
      pend_io_addr_reg <= 5'h00;
      pend_io_val_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cyc_last_reg <= cyc_last_next;
      opnd_reg <= opnd_next;
      pc_reg <= pc_next;
      z_reg <= z_next;
      sp_reg <= sp_next;
      ret_reg <= ret_next;
      flags_reg <= flags_next;
      result_reg <= result_next;
      prdata_reg <= prdata_next;
      io_reg <= io_next;
      pend_pc_reg <= pend_pc_next;
      pend_flags_reg <= pend_flags_next;
      pend_res_reg <= pend_res_next;
      pend_push_reg <= pend_push_next;
      pend_io_we_reg <= pend_io_we_next;
      pend_io_addr_reg <= pend_io_addr_next;
      pend_io_val_reg <= pend_io_val_next;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  set_bits_result_a: assert property ( // see RQ1
    launch && op_code == cbs_pkg::set_bits_op |-> ##2 result_reg == ($past(d_val, 2) | $past(kimm, 2)))
    else $error("set-bits result wrong");

  clear_bits_result_a: assert property ( // see RQ2
    launch && op_code == cbs_pkg::clear_bits_op |-> ##2 result_reg == ($past(d_val, 2) & ~$past(kimm, 2)))
    else $error("clear-bits result wrong");

  test_flags_a: assert property ( // see RQ3
    launch && op_code == cbs_pkg::test_zero_minus_op |-> ##2
    flags_reg[`CBS_FLAG_Z] == ($past(d_val, 2) == 8'h00) && !flags_reg[`CBS_FLAG_V] && result_reg == $past(d_val, 2))
    else $error("test flags wrong");

  indirect_jump_op_timing_a: assert property ( // see RQ4
    launch && op_code == cbs_pkg::indirect_jump_op |=> exec_busy [*2] ##1 (!exec_busy && pc_reg == $past(z_reg, 3)))
    else $error("indirect jump timing or target wrong");

  indirect_call_op_push_a: assert property ( // see RQ5
    launch && op_code == cbs_pkg::indirect_call_op |=> exec_busy [*3] ##1
    (ret_reg == $past(pc_reg, 4) + `CBS_PC_STEP && sp_reg == $past(sp_reg, 4) - `CBS_SP_STEP))
    else $error("indirect call push wrong");

  cpi_carry_a: assert property ( // see RQ7
    launch && op_code == cbs_pkg::compare_immediate_op |-> ##2
    flags_reg[`CBS_FLAG_C] == ($past(d_val, 2) < $past(kimm, 2)) && result_reg == $past(result_reg, 2))
    else $error("compare immediate carry wrong");

  skip_two_word_a: assert property ( // see RQ22
    launch && x_skip && op_two |=> exec_busy [*3] ##1 (!exec_busy && pc_reg == $past(pc_reg, 4) + `CBS_SKIP_TWO))
    else $error("two-word skip wrong");

  signed_ge_take_a: assert property ( // see RQ12
    launch && op_code == cbs_pkg::branch_signed_ge_op && !(flags_reg[`CBS_FLAG_N] ^ flags_reg[`CBS_FLAG_V])
    |-> ##3 pc_reg == $past(pc_reg, 3) + $past(kofs, 3) + `CBS_PC_STEP)
    else $error("signed branch not taken");

  branch_untaken_a: assert property ( // see RQ22
    launch && op_code >= cbs_pkg::branch_flag_set_op && op_code <= cbs_pkg::branch_irq_disabled_op && !x_take
    |=> exec_busy ##1 (!exec_busy && pc_reg == $past(pc_reg, 2) + `CBS_PC_STEP && flags_reg == $past(flags_reg, 2)))
    else $error("untaken branch wrong");

  io_bit_set_a: assert property ( // see RQ20
    launch && op_code == cbs_pkg::io_bit_set_op && 32'(op_io) < IO_REGS |-> ##3
    io_reg[pend_io_addr_reg] == ($past(io_val, 3) | $past(io_mask, 3)))
    else $error("I/O bit set wrong");

endmodule : cbs_exec

// [design/cbs_params.svh]
// Register offsets, field positions, reset values and cycle counts of the execution block
`ifndef CBS_PARAMS_SVH
`define CBS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CBS_OFF_OP 8'h00
`define CBS_OFF_OPND 8'h04
`define CBS_OFF_PC 8'h08
`define CBS_OFF_ZPTR 8'h0C
`define CBS_OFF_SP 8'h10
`define CBS_OFF_FLAGS 8'h14
`define CBS_OFF_RESULT 8'h18
`define CBS_OFF_STAT 8'h1C
`define CBS_OFF_RET 8'h20
`define CBS_OFF_IO_BASE 8'h80

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CBS_OPF_CODE 4:0
`define CBS_OPF_SEL 10:8
`define CBS_OPF_IO 20:16
`define CBS_OPF_TWO 24
`define CBS_ODF_D 7:0
`define CBS_ODF_R 15:8
`define CBS_ODF_KIMM 23:16
`define CBS_ODF_KOFS 31:24
`define CBS_STF_CYC 2:0
`define CBS_STF_BUSY 8
`define CBS_FLAG_C 0
`define CBS_FLAG_Z 1
`define CBS_FLAG_N 2
`define CBS_FLAG_V 3
`define CBS_FLAG_H 5
`define CBS_FLAG_T 6
`define CBS_FLAG_I 7

// ----------------------------------------------------------------------
// Reset values, constants and cycle counts
// ----------------------------------------------------------------------
`define CBS_PC_RST 16'h0000
`define CBS_Z_RST 16'h0000
`define CBS_SP_RST 16'h007F
`define CBS_FLAGS_RST 8'h00
`define CBS_BYTE_ONES 8'hFF
`define CBS_OP_COUNT 5'h1D
`define CBS_PC_STEP 16'h0001
`define CBS_SKIP_ONE 16'h0002
`define CBS_SKIP_TWO 16'h0003
`define CBS_SP_STEP 16'h0002
`define CBS_CYC_ONE 3'h1
`define CBS_CYC_TWO 3'h2
`define CBS_CYC_THREE 3'h3

`endif

// [design/cbs_pkg.sv]
// Types shared by the branch, skip and bit-operation execution block
package cbs_pkg;

  // Operation codes, numbered 0 upward in this order
  typedef enum logic [4:0] {
    set_bits_op, clear_bits_op, test_zero_minus_op, indirect_jump_op, indirect_call_op,
    compare_skip_equal_op, compare_immediate_op, skip_reg_bit_clear_op, skip_reg_bit_set_op,
    skip_io_bit_clear_op, skip_io_bit_set_op, branch_flag_set_op, branch_flag_clear_op,
    branch_signed_ge_op, branch_signed_lt_op, branch_unsigned_ge_op, branch_unsigned_lt_op,
    branch_carry_clear_op, branch_carry_set_op, branch_halfcarry_set_op, branch_halfcarry_clear_op,
    branch_transfer_set_op, branch_transfer_clear_op, branch_overflow_set_op, branch_overflow_clear_op,
    branch_irq_enabled_op, branch_irq_disabled_op, io_bit_set_op, io_bit_clear_op
  } cbs_op_e;

  // Execution sequencer states
  typedef enum logic {
    st_idle,
    st_busy
  } cbs_state_e;

endpackage : cbs_pkg

// [dv/tb.sv]
// Self-checking bench for the branch, skip and bit-operation execution unit
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic exec_busy;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [15:0] sp_m = 16'h007F;
  logic [15:0] z_m;
  logic [7:0] io_m;
  logic [7:0] res_m;
  int fails = 0;
  int total_checks = 0;
  int seed = 93269;
  int bidx[12] = '{0, 0, 0, 0, 5, 5, 6, 6, 3, 3, 7, 7};
  logic [11:0] binv = 12'hAA5;

  cbs_exec cbs_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .exec_busy(exec_busy));

  // ----------------------------------------------------------------------
  // Clock, compare and closing
  // ----------------------------------------------------------------------
  always #50 pclk = ~pclk;

  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  // Monitor takes the oldest note at each completed access
  always @(posedge pclk) begin
    if (psel && penable && pready && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk({pslverr, pwrite ? e[31:0] : prdata}, e);
    end
  end

  // One APB transfer; notes error flag and read data expected
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err,
                     input logic [31:0] want);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back({err, want});
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  // Launch one operation with random operands and predict its outcome
  task automatic run_op(input logic [4:0] code);
    logic [31:0] od;
    logic [7:0] f;
    logic [7:0] a;
    logic [7:0] k;
    logic [15:0] pc;
    logic [15:0] pce;
    logic [2:0] sel;
    logic [2:0] cyc;
    logic two;
    logic cond;
    int n;
    od = $random(seed);
    if (od[0] || code == 5'h07 || code == 5'h08) od[15:8] = od[7:0];
    f = $random(seed);
    pc = $random(seed);
    sel = $random(seed);
    two = $random(seed);
    a = od[7:0];
    k = od[23:16];
    cond = 1'b0;
    cyc = 3'h1;
    pce = pc + 16'h0001;
    case (code)
      5'h00: res_m = a | k;
      5'h01: res_m = a & (8'hFF - k);
      5'h02: res_m = a;
      5'h05: cond = a == od[15:8];
      5'h07: cond = !a[sel];
      5'h08: cond = a[sel];
      5'h09: cond = !io_m[sel];
      5'h0A: cond = io_m[sel];
      5'h0B: cond = f[sel];
      5'h0C: cond = !f[sel];
      5'h0D: cond = !(f[2] ^ f[3]);
      5'h0E: cond = f[2] ^ f[3];
      5'h1B: io_m[sel] = 1'b1;
      5'h1C: io_m[sel] = 1'b0;
      default: if (code > 5'h0E) cond = f[bidx[code - 15]] ^ binv[code - 15];
    endcase
    if (code < 5'h03) begin
      f[3:1] = {1'b0, res_m[7], res_m == 8'h00};
    end else if (code == 5'h06) begin
      a = a - k;
      f[3:0] = {(od[7] & !k[7] & !a[7]) | (!od[7] & k[7] & a[7]), a[7], a == 8'h00,
        (!od[7] & k[7]) | (k[7] & a[7]) | (a[7] & !od[7])};
      f[5] = (!od[3] & k[3]) | (k[3] & a[3]) | (a[3] & !od[3]);
    end else if (code == 5'h03 || code == 5'h04) begin
      pce = z_m;
      cyc = code == 5'h03 ? 3'h2 : 3'h3;
    end else if (code > 5'h1A) cyc = 3'h2;
    else if (cond && code > 5'h0A) begin
      pce = pc + {{8{od[31]}}, od[31:24]} + 16'h0001;
      cyc = 3'h2;
    end else if (cond) begin
      pce = pc + 16'h0002 + {15'h0000, two};
      cyc = 3'h2 + {2'h0, two};
    end
    acc(1'b1, 8'h04, od, 1'b0, 32'h0);
    acc(1'b1, 8'h14, {24'h0, f}, 1'b0, 32'h0);
    acc(1'b1, 8'h08, {16'h0, pc}, 1'b0, 32'h0);
    acc(1'b1, 8'h00, {7'h00, two, 13'h0000, sel, 3'h0, code}, 1'b0, 32'h0);
    if (code == 5'h04) acc(1'b1, 8'h14, 32'h0, 1'b1, 32'h0);
    #1;
    n = 0;
    while (exec_busy === 1'b1 && n < 10) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk({32'h0, exec_busy}, 33'h0);
    if (code == 5'h04) sp_m = sp_m - 16'h0002;
    acc(1'b0, 8'h08, 32'h0, 1'b0, {16'h0, pce});
    acc(1'b0, 8'h14, 32'h0, 1'b0, {24'h0, f});
    acc(1'b0, 8'h1C, 32'h0, 1'b0, {29'h0, cyc});
    acc(1'b0, 8'h18, 32'h0, 1'b0, {24'h0, res_m});
    acc(1'b0, 8'h10, 32'h0, 1'b0, {16'h0, sp_m});
    acc(1'b0, 8'h80, 32'h0, 1'b0, {24'h0, io_m});
    if (code == 5'h04) acc(1'b0, 8'h20, 32'h0, 1'b0, {16'h0, pc + 16'h0001});
  endtask : run_op

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    z_m = $random(seed);
    io_m = $random(seed);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, 8'h08, 32'h0, 1'b0, 32'h0);
    acc(1'b0, 8'h10, 32'h0, 1'b0, 32'h0000007F);
    acc(1'b0, 8'h14, 32'h0, 1'b0, 32'h0);
    acc(1'b0, 8'h40, 32'h0, 1'b1, 32'h0);
    acc(1'b1, 8'h00, 32'h0000001D, 1'b1, 32'h0);
    $display("reset and refusal test done");
    acc(1'b1, 8'h0C, {16'h0, z_m}, 1'b0, 32'h0);
    acc(1'b1, 8'h80, {24'h0, io_m}, 1'b0, 32'h0);
    for (int c = 0; c < 29; c++) repeat (3) run_op(c[4:0]);
    $display("operation sweep done");
    close_out();
  end

  initial begin
    #2000000;
    fails++;
    close_out();
  end
endmodule : tb
